// file: low_voltage_detector_ctrl.sv
`timescale 1ns/100ps

module low_voltage_detector_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [lvd_pkg::ADDR_W-1:0] addr_i,
	input wire logic [lvd_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [lvd_pkg::DATA_W-1:0] rdata_o,
	// Analog comparator
	input wire logic supply_below_i,
	input wire logic ext_below_i,
	output logic cmp_enable_o,
	output logic level_select_o,
	output logic ext_select_o,
	// Interrupt and reset
	output logic detector_irq_o,
	output logic irq_o,
	output logic det_reset_o
);

	typedef struct packed {
		logic ctrl_on;
		logic ctrl_action;
		logic ctrl_source;
		logic level_sel;
		logic irq_req;
		logic irq_mask;
		logic reset_cause;
		logic prev_flag;
		logic irq_pulse;
		logic det_rst;
		logic [lvd_pkg::STAB_W-1:0] stab_cnt;
		logic [lvd_pkg::DATA_W-1:0] rdata;
	} lvd_state_t;

	localparam logic [lvd_pkg::STAB_W-1:0] STAB_END = lvd_pkg::STAB_W'(lvd_pkg::STAB_CYCLES);

	lvd_state_t st;
	lvd_state_t next_st;

	logic supply_below;
	logic ext_below;
	logic flag;
	logic crossing;
	logic irq_event;
	logic settled;

	// Comparator outputs come from the analog domain
	level_sync u_sync_supply (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(supply_below_i),
		.level_o(supply_below)
	);

	level_sync u_sync_ext (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(ext_below_i),
		.level_o(ext_below)
	);

	// Read image of one register
	function automatic logic [lvd_pkg::DATA_W-1:0] reg_image(
		input logic [lvd_pkg::ADDR_W-1:0] addr,
		input lvd_state_t s,
		input logic below,
		input logic done
	);
		logic [lvd_pkg::DATA_W-1:0] v;
		v = '0;
		case (addr)
			lvd_pkg::OFS_CONTROL: begin
				v[lvd_pkg::BIT_BELOW_FLAG] = below;
				v[lvd_pkg::BIT_ACTION] = s.ctrl_action;
				v[lvd_pkg::BIT_SOURCE] = s.ctrl_source;
				v[lvd_pkg::BIT_ON] = s.ctrl_on;
			end
			lvd_pkg::OFS_THRESHOLD: begin
				v[lvd_pkg::BIT_LEVEL] = s.level_sel;
			end
			lvd_pkg::OFS_IRQ_STATUS: begin
				v[lvd_pkg::BIT_IRQ_REQ] = s.irq_req;
			end
			lvd_pkg::OFS_IRQ_MASK: begin
				v[lvd_pkg::BIT_IRQ_MASK] = s.irq_mask;
			end
			lvd_pkg::OFS_RESET_CAUSE: begin
				v[lvd_pkg::BIT_CAUSE] = s.reset_cause;
			end
			lvd_pkg::OFS_DET_STATE: begin
				v[lvd_pkg::BIT_SETTLED] = done;
				v[lvd_pkg::BIT_RST_ACTIVE] = s.det_rst;
			end
			default: begin
				v = '0;
			end
		endcase
		return v;
	endfunction : reg_image

	// Live level of the selected source, zero while disabled
	always_comb begin
		if (!st.ctrl_on) begin
			flag = 1'b0;
		end else if (st.ctrl_source == lvd_pkg::SOURCE_EXT) begin
			flag = ext_below;
		end else begin
			flag = supply_below;
		end
	end

	// Either direction of crossing counts, including the fall when disabled
	assign crossing = flag != st.prev_flag;
	assign irq_event = crossing && (st.ctrl_action == lvd_pkg::ACTION_IRQ);
	assign settled = st.stab_cnt == STAB_END;

	always_comb begin
		next_st = st;
		next_st.prev_flag = flag;
		next_st.irq_pulse = irq_event;
		next_st.rdata = '0;

		// Settling counter restarts whenever the comparator is off
		if (!st.ctrl_on) begin
			next_st.stab_cnt = '0;
		end else if (!settled) begin
			next_st.stab_cnt = st.stab_cnt + lvd_pkg::STAB_W'(1);
		end

		// Register writes
		if (wr_i) begin
			case (addr_i)
				lvd_pkg::OFS_CONTROL: begin
					next_st.ctrl_on = wdata_i[lvd_pkg::BIT_ON];
					next_st.ctrl_action = wdata_i[lvd_pkg::BIT_ACTION];
					next_st.ctrl_source = wdata_i[lvd_pkg::BIT_SOURCE];
				end
				lvd_pkg::OFS_THRESHOLD: begin
					next_st.level_sel = wdata_i[lvd_pkg::BIT_LEVEL];
				end
				lvd_pkg::OFS_IRQ_MASK: begin
					next_st.irq_mask = wdata_i[lvd_pkg::BIT_IRQ_MASK];
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end

		// Reads answer next cycle; status bits clear on read
		if (rd_i) begin
			next_st.rdata = reg_image(addr_i, st, flag, settled);
			if (addr_i == lvd_pkg::OFS_IRQ_STATUS) begin
				next_st.irq_req = 1'b0;
			end
			if (addr_i == lvd_pkg::OFS_RESET_CAUSE) begin
				next_st.reset_cause = 1'b0;
			end
		end

		// Hardware sets win over a clearing read
		if (irq_event) begin
			next_st.irq_req = 1'b1;
		end

		// Reset mode: assert while the selected level is below
		next_st.det_rst = st.ctrl_on && (st.ctrl_action == lvd_pkg::ACTION_RESET) && flag;

		// A detector reset masks the interrupt and records its cause only
		if (st.det_rst) begin
			next_st.irq_mask = 1'b1;
			next_st.reset_cause = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			// Any other reset clears control and masks the interrupt
			st.ctrl_on <= lvd_pkg::RST_ON;
			st.ctrl_action <= lvd_pkg::RST_ACTION;
			st.ctrl_source <= lvd_pkg::RST_SOURCE;
			st.level_sel <= lvd_pkg::RST_LEVEL;
			st.irq_req <= lvd_pkg::RST_IRQ_REQ;
			st.irq_mask <= lvd_pkg::RST_IRQ_MASK;
			st.reset_cause <= lvd_pkg::RST_CAUSE;
			st.prev_flag <= 1'b0;
			st.irq_pulse <= 1'b0;
			st.det_rst <= 1'b0;
			st.stab_cnt <= '0;
			st.rdata <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign rdata_o = st.rdata;
	assign cmp_enable_o = st.ctrl_on;
	assign level_select_o = st.level_sel;
	assign ext_select_o = st.ctrl_source;
	assign detector_irq_o = st.irq_pulse;
	assign irq_o = st.irq_req && !st.irq_mask;
	assign det_reset_o = st.det_rst;

	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (sys_rst_i);

	a_supply_crossing_irq: assert property (
		(st.ctrl_source == lvd_pkg::SOURCE_SUPPLY && !st.ctrl_action && crossing)
		|=> detector_irq_o && st.irq_req)
		else $error("Supply crossing in interrupt mode gave no interrupt");

	a_ext_crossing_irq: assert property (
		(st.ctrl_source == lvd_pkg::SOURCE_EXT && !st.ctrl_action && crossing)
		|=> detector_irq_o && st.irq_req)
		else $error("External crossing in interrupt mode gave no interrupt");

	a_flag_readback: assert property (
		(rd_i && addr_i == lvd_pkg::OFS_CONTROL)
		|=> rdata_o[lvd_pkg::BIT_BELOW_FLAG] == $past(flag))
		else $error("Control read does not show the below flag");

	a_ctrl_fields: assert property (
		(wr_i && addr_i == lvd_pkg::OFS_CONTROL)
		|=> st.ctrl_action == $past(wdata_i[lvd_pkg::BIT_ACTION])
			&& st.ctrl_source == $past(wdata_i[lvd_pkg::BIT_SOURCE]))
		else $error("Control fields not taken from write data");

	a_no_rst_above: assert property (
		!flag |=> !det_reset_o)
		else $error("Detector reset raised while level above threshold");

	a_mask_on_reset: assert property (
		det_reset_o |=> st.irq_mask)
		else $error("Interrupt mask not set by detector reset");

	a_off_below_irq: assert property (
		(st.ctrl_on && flag && !st.ctrl_action && wr_i && addr_i == lvd_pkg::OFS_CONTROL
			&& !wdata_i[lvd_pkg::BIT_ON] && !wdata_i[lvd_pkg::BIT_ACTION])
		|=> ##1 detector_irq_o)
		else $error("Disabling below threshold gave no interrupt");

	a_cause_recorded: assert property (
		det_reset_o |=> st.reset_cause)
		else $error("Detector reset not recorded as cause");

	a_rst_held_below: assert property (
		(st.ctrl_on && st.ctrl_action && flag) |=> det_reset_o)
		else $error("Reset mode below threshold without reset");

	a_ctrl_survives: assert property (
		(det_reset_o && !wr_i)
		|=> $stable(st.ctrl_on) && $stable(st.ctrl_action) && $stable(st.ctrl_source))
		else $error("Detector reset disturbed control bits");

	a_status_sticky: assert property (
		(st.irq_req && !(rd_i && addr_i == lvd_pkg::OFS_IRQ_STATUS))
		|=> st.irq_req)
		else $error("Interrupt request dropped without a status read");

	a_status_clear: assert property (
		(rd_i && addr_i == lvd_pkg::OFS_IRQ_STATUS && !irq_event)
		|=> !st.irq_req)
		else $error("Status read did not clear the interrupt request");

	a_status_no_spur: assert property (
		(!st.irq_req && !irq_event)
		|=> !st.irq_req)
		else $error("Interrupt request set without a crossing");

	a_no_irq_resetmode: assert property (
		(st.ctrl_action == lvd_pkg::ACTION_RESET)
		|=> !detector_irq_o)
		else $error("Interrupt pulse raised in reset mode");

	a_no_rst_irqmode: assert property (
		(st.ctrl_action == lvd_pkg::ACTION_IRQ)
		|=> !det_reset_o)
		else $error("Detector reset raised in interrupt mode");

	a_masked_quiet: assert property (
		st.irq_mask
		|-> !irq_o)
		else $error("Interrupt output high while masked");

	a_mask_write: assert property (
		(wr_i && addr_i == lvd_pkg::OFS_IRQ_MASK && !det_reset_o)
		|=> st.irq_mask == $past(wdata_i[lvd_pkg::BIT_IRQ_MASK]))
		else $error("Mask not taken from write data");

	a_flag_off_reads: assert property (
		(rd_i && addr_i == lvd_pkg::OFS_CONTROL && !st.ctrl_on)
		|=> !rdata_o[lvd_pkg::BIT_BELOW_FLAG])
		else $error("Below flag read high while detector off");

	a_rdata_idle: assert property (
		!rd_i
		|=> rdata_o == '0)
		else $error("Read data not zero outside the read answer cycle");

	a_cause_sticky: assert property (
		(st.reset_cause && !(rd_i && addr_i == lvd_pkg::OFS_RESET_CAUSE))
		|=> st.reset_cause)
		else $error("Reset cause dropped without a read");

	a_cause_only_det: assert property (
		(!st.reset_cause && !det_reset_o)
		|=> !st.reset_cause)
		else $error("Reset cause set without a detector reset");

	a_cause_read: assert property (
		(rd_i && addr_i == lvd_pkg::OFS_RESET_CAUSE)
		|=> rdata_o[lvd_pkg::BIT_CAUSE] == $past(st.reset_cause))
		else $error("Reset cause read does not show the recorded cause");

	a_rst_off: assert property (
		!st.ctrl_on
		|=> !det_reset_o)
		else $error("Detector reset raised while detector off");

	a_ctrl_on_write: assert property (
		(wr_i && addr_i == lvd_pkg::OFS_CONTROL)
		|=> st.ctrl_on == $past(wdata_i[lvd_pkg::BIT_ON]))
		else $error("Detector on bit not taken from write data");

endmodule : low_voltage_detector_ctrl

// file: lvd_pkg.sv
package lvd_pkg;

	// Register bus geometry
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;

	// Register offsets
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_THRESHOLD = 3'h1;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h2;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h3;
	localparam logic [2:0] OFS_RESET_CAUSE = 3'h4;
	localparam logic [2:0] OFS_DET_STATE = 3'h5;

	// Field positions in detector_control_reg
	localparam int BIT_BELOW_FLAG = 0;
	localparam int BIT_ACTION = 1;
	localparam int BIT_SOURCE = 2;
	localparam int BIT_ON = 7;

	// Field positions in the other registers
	localparam int BIT_LEVEL = 0;
	localparam int BIT_IRQ_REQ = 0;
	localparam int BIT_IRQ_MASK = 0;
	localparam int BIT_CAUSE = 0;
	localparam int BIT_SETTLED = 0;
	localparam int BIT_RST_ACTIVE = 1;

	// Reset values
	localparam logic RST_ON = 1'h0;
	localparam logic RST_ACTION = 1'h0;
	localparam logic RST_SOURCE = 1'h0;
	localparam logic RST_LEVEL = 1'h0;
	localparam logic RST_IRQ_REQ = 1'h0;
	localparam logic RST_IRQ_MASK = 1'h1;
	localparam logic RST_CAUSE = 1'h0;

	// Mode encodings
	localparam logic ACTION_IRQ = 1'h0;
	localparam logic ACTION_RESET = 1'h1;
	localparam logic SOURCE_SUPPLY = 1'h0;
	localparam logic SOURCE_EXT = 1'h1;

	// Comparator settling time
	localparam int CLK_PERIOD_NS = 10;
	localparam int STAB_TIME_NS = 10000;
	localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STAB_W = 10;

endpackage : lvd_pkg

// file: level_sync.sv
`timescale 1ns/100ps

module level_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Asynchronous level in, filtered level out
	input wire logic async_i,
	output logic level_o
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = async_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// Accept a change once the two later stages agree
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level_o = st.q;

	a_sync_agree_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!$stable(st.q) |-> $past(st.s2) == $past(st.s3))
		else $error("Synchronised level changed without stage agreement");

endmodule : level_sync

// file: lvd_comparator_model.sv
`timescale 1ns/100ps

module lvd_comparator_model (
	// Comparator control from the block
	input wire logic cmp_enable_i,
	// Analog levels set by the bench
	input wire logic supply_low_i,
	input wire logic ext_low_i,
	// Comparator outputs
	output logic supply_below_o,
	output logic ext_below_o
);
	// A disabled comparator reports at-or-above
	assign supply_below_o = cmp_enable_i & supply_low_i;
	assign ext_below_o = cmp_enable_i & ext_low_i;
endmodule : lvd_comparator_model

// file: low_voltage_detector_ctrl_tb.sv
`timescale 1ns/100ps

module low_voltage_detector_ctrl_tb;
	localparam logic [2:0] CTL = lvd_pkg::OFS_CONTROL;
	localparam logic [2:0] THR = lvd_pkg::OFS_THRESHOLD;
	localparam logic [2:0] STA = lvd_pkg::OFS_IRQ_STATUS;
	localparam logic [2:0] MSK = lvd_pkg::OFS_IRQ_MASK;
	localparam logic [2:0] CAU = lvd_pkg::OFS_RESET_CAUSE;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic supply_below_i;
	logic ext_below_i;
	logic cmp_enable_o;
	logic level_select_o;
	logic ext_select_o;
	logic detector_irq_o;
	logic irq_o;
	logic det_reset_o;
	logic supply_low = 1'b0;
	logic ext_low = 1'b0;
	logic [7:0] d;
	int errors = 0;
	int samples_checked = 0;
	int pulses = 0;

	always #5 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (detector_irq_o === 1'b1) begin
			pulses = pulses + 1;
		end
	end

	lvd_comparator_model cmp_u (
		.cmp_enable_i(cmp_enable_o),
		.supply_low_i(supply_low),
		.ext_low_i(ext_low),
		.supply_below_o(supply_below_i),
		.ext_below_o(ext_below_i)
	);

	low_voltage_detector_ctrl dut_u (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.supply_below_i(supply_below_i),
		.ext_below_i(ext_below_i),
		.cmp_enable_o(cmp_enable_o),
		.level_select_o(level_select_o),
		.ext_select_o(ext_select_o),
		.detector_irq_o(detector_irq_o),
		.irq_o(irq_o),
		.det_reset_o(det_reset_o)
	);

	task automatic give_verdict;
		$display("checks %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask : rd

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask : rchk

	// Synchroniser and event latency stays well below this
	task automatic gap;
		repeat (12) @(posedge clk_i);
	endtask : gap

	task automatic settle;
		for (int i = 0; i < 1200; i++) begin
			rd(lvd_pkg::OFS_DET_STATE, d);
			if (d[lvd_pkg::BIT_SETTLED] === 1'b1) break;
		end
		chk({7'h00, d[lvd_pkg::BIT_SETTLED]}, 8'h01);
	endtask : settle

	// One crossing: one pulse, request raised, cleared by the status read
	task automatic crossing(input logic sup, input logic ext, input logic [7:0] ctl);
		pulses = 0;
		supply_low <= sup;
		ext_low <= ext;
		gap();
		chk(pulses[7:0], 8'h01);
		chk({7'h00, irq_o}, 8'h01);
		rchk(CTL, ctl);
		rchk(STA, 8'h01);
		chk({7'h00, irq_o}, 8'h00);
	endtask : crossing

	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rchk(MSK, 8'h01);
		rchk(CTL, 8'h00);
		rchk(CAU, 8'h00);
		rchk(3'h7, 8'h00);
		wr(STA, 8'hFF);
		rchk(STA, 8'h00);
		chk({7'h00, irq_o}, 8'h00);
		$display("test reset_values done");
		wr(THR, 8'h01);
		wr(CTL, 8'h80);
		settle();
		chk({6'h00, level_select_o, cmp_enable_o}, 8'h03);
		rchk(CTL, 8'h80);
		rd(STA, d);
		wr(MSK, 8'h00);
		crossing(1'b1, 1'b0, 8'h81);
		crossing(1'b0, 1'b0, 8'h80);
		$display("test supply_irq done");
		wr(CTL, 8'h00);
		wr(CTL, 8'h84);
		settle();
		chk({7'h00, ext_select_o}, 8'h01);
		rd(STA, d);
		crossing(1'b0, 1'b1, 8'h85);
		crossing(1'b0, 1'b0, 8'h84);
		ext_low <= 1'b1;
		gap();
		rd(STA, d);
		pulses = 0;
		wr(CTL, 8'h04);
		gap();
		chk(pulses[7:0], 8'h01);
		rchk(STA, 8'h01);
		ext_low <= 1'b0;
		$display("test ext_irq done");
		wr(MSK, 8'h01);
		wr(CTL, 8'h80);
		settle();
		rchk(CTL, 8'h80);
		rd(STA, d);
		wr(CTL, 8'h82);
		gap();
		chk({7'h00, det_reset_o}, 8'h00);
		pulses = 0;
		supply_low <= 1'b1;
		gap();
		chk({7'h00, det_reset_o}, 8'h01);
		chk(pulses[7:0], 8'h00);
		rchk(CAU, 8'h01);
		rchk(MSK, 8'h01);
		rchk(CTL, 8'h83);
		rchk(lvd_pkg::OFS_DET_STATE, 8'h03);
		supply_low <= 1'b0;
		gap();
		chk({7'h00, det_reset_o}, 8'h00);
		rchk(CAU, 8'h01);
		rchk(CAU, 8'h00);
		wr(CTL, 8'h00);
		rchk(CTL, 8'h00);
		$display("test supply_reset done");
		wr(CTL, 8'h84);
		settle();
		wr(CTL, 8'h86);
		wr(MSK, 8'h00);
		ext_low <= 1'b1;
		gap();
		chk({7'h00, det_reset_o}, 8'h01);
		rchk(MSK, 8'h01);
		ext_low <= 1'b0;
		gap();
		chk({7'h00, det_reset_o}, 8'h00);
		wr(MSK, 8'h00);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		rchk(CTL, 8'h00);
		rchk(MSK, 8'h01);
		rchk(CAU, 8'h00);
		$display("test ext_reset done");
		give_verdict();
	end

	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule : low_voltage_detector_ctrl_tb
